// ==== logic/facs_defines.vh ====
`ifndef FACS_DEFINES_VH
`define FACS_DEFINES_VH

// Register indices
`define FACS_A_WDL      4'h0
`define FACS_A_WDH      4'h1
`define FACS_A_SAL      4'h2
`define FACS_A_SAH      4'h3
`define FACS_A_EAL      4'h4
`define FACS_A_EAH      4'h5
`define FACS_A_ARS      4'h6
`define FACS_A_MSC      4'h7
`define FACS_A_ESC      4'h8
`define FACS_A_CLR      4'h9
`define FACS_A_PMC      4'hA
`define FACS_A_STH      4'hB
`define FACS_A_STL      4'hC

// Main control fields
`define FACS_MSC_GO     7
`define FACS_MSC_AREA   3
// Extra control fields
`define FACS_ESC_GO     7
// Area select register
`define FACS_ARS_XAREA  0
// Program mode control fields
`define FACS_PMC_CPM    0
`define FACS_PMC_CPB    1
`define FACS_PMC_DPM    2
// Status high fields
`define FACS_STH_EDONE  7
`define FACS_STH_MDONE  6
// Status low fields
`define FACS_STL_EERR   5

// Main commands {area, code}
`define FACS_CMD_WRITE  4'h1
`define FACS_CMD_BCC    4'h3
`define FACS_CMD_BCD    4'hB
`define FACS_CMD_ERASE  4'h4
// Extra commands
`define FACS_XCMD_SHLD  4'h1
`define FACS_XCMD_RDPR  4'h6
`define FACS_XCMD_BOOT  4'h7

// Lock bit positions in stored extra words
`define FACS_SHLD_LOCK  15
`define FACS_RDPR_LOCK  31
`define FACS_BOOT_LOCK  9

// Address layout
`define FACS_DF_BASE    20'hF1000
`define FACS_CBLK_SH    11
`define FACS_DBLK_SH    8
`define FACS_ZERO8      8'h00
`define FACS_ONES32     32'hFFFFFFFF

`endif

// ==== logic/facs_flash_port.v ====
`timescale 1ns/1ps
`default_nettype none
`include "facs_defines.vh"

// Small flash array model port: byte lane access, blank and extra words
module facs_flash_port
(
    // Clock and reset
    input  wire        sys_clk_i,
    input  wire        rst_b_i,
    // Operation strobes
    input  wire        wr_i,
    input  wire        wide_i,
    input  wire        erase_i,
    input  wire [19:0] addr_i,
    input  wire [31:0] data_i,
    input  wire        xwr_i,
    input  wire [1:0]  xsel_i,
    // Results
    output reg  [7:0]  byte_o,
    output reg  [31:0] xword_o
);
    // ----------------------------------------
    // Storage
    // ----------------------------------------
    reg [7:0]  mem_q [0:255];
    reg [31:0] ext_q [0:3];
    wire [7:0] idx = addr_i[7:0];
    integer    k;

    // Writes, erases and reads of the array
    always @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            for (k = 0; k < 256; k = k + 1)
                mem_q[k] <= `FACS_ZERO8;
            for (k = 0; k < 4; k = k + 1)
                ext_q[k] <= `FACS_ONES32;
            byte_o  <= `FACS_ZERO8;
            xword_o <= `FACS_ONES32;
        end
        else
        begin
            if (erase_i)
                mem_q[idx] <= `FACS_ZERO8;
            else if (wr_i)
            begin
                mem_q[idx] <= data_i[7:0];
                if (wide_i)
                begin
                    mem_q[idx + 8'h01] <= data_i[15:8];
                    mem_q[idx + 8'h02] <= data_i[23:16];
                    mem_q[idx + 8'h03] <= data_i[31:24];
                end
            end
            if (xwr_i)
                ext_q[xsel_i] <= data_i;
            byte_o  <= mem_q[idx];
            xword_o <= ext_q[xsel_i];
        end
    end
endmodule
`default_nettype wire

// ==== logic/facs_sequencer.v ====
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "facs_defines.vh"

// What this block does
// - Command 001 writes four or one byte
// - Command 011 blank-checks code area range
// - Area 1 command 011 blank-checks data area
// - Command 100 erases blocks start through end
// - Blocks 2 Kbytes code, 256 bytes data
// - Main control writable in allowed modes
// - Register clear only when both stopped
// - Extra 0001 shield write, bit 15 locks
// - Extra 0110 readprot write, bit 31 locks
// - Extra 0111 boot write, bit 9 locks
// - Some reads undefined after extra start
// - Extra control writable in code mode only
// - Main go runs selected command
// - Register clear resets all registers but mode and status
module facs_sequencer
(
    // Clock and reset
    input  wire        sys_clk_i,
    input  wire        rst_b_i,
    // Register port
    input  wire [3:0]  addr_i,
    input  wire [7:0]  wdata_i,
    input  wire        wr_i,
    input  wire        rd_i,
    output reg  [7:0]  rdata_o,
    // Status
    output wire        main_done_flag_o,
    output wire        extra_done_flag_o
);
    // ----------------------------------------
    // State codes
    // ----------------------------------------
    localparam [2:0] S_IDLE = 3'd0;
    localparam [2:0] S_WR   = 3'd1;
    localparam [2:0] S_BC   = 3'd2;
    localparam [2:0] S_ER   = 3'd3;
    localparam [2:0] S_XRD  = 3'd4;
    localparam [2:0] S_XWR  = 3'd5;
    localparam [2:0] S_DONE = 3'd6;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg [7:0]  wdl_q, wdh_q, wdl2_q, wdh2_q;
    reg [7:0]  sal_q, sah_q, eal_q, eah_q;
    reg        xarea_q;
    reg [7:0]  msc_q, esc_q;
    reg [2:0]  pmc_q;
    reg        mdone_q, xdone_q, xerr_q, berr_q;
    reg [2:0]  st_q;
    reg [19:0] cur_q;
    reg        wait_q;
    reg        fl_wr, fl_wide, fl_er, fl_xwr;

    wire [19:0] start_a = {sah_q[3:0], sal_q, wdh2_q};
    wire [19:0] end_a   = {eah_q[3:0], eal_q, wdl2_q};
    wire [31:0] wdata   = {wdh_q, wdh2_q, wdl_q, wdl2_q};
    wire [3:0]  mcmd    = {msc_q[`FACS_MSC_AREA], msc_q[2:0]};
    wire [3:0]  xcmd    = esc_q[3:0];
    wire        cur_df  = (cur_q >= `FACS_DF_BASE);
    wire        start_df = (start_a >= `FACS_DF_BASE);
    wire [7:0]  fl_byte;
    wire [31:0] fl_xword;
    wire [1:0]  xsel    = xcmd[1:0];
    wire        stopped = !mdone_q && !xdone_q;
    wire        clr_w   = wr_i && (addr_i == `FACS_A_CLR) && wdata_i[0];

    // Block number of an address, data area blocks are smaller
    function [19:0] blk;
        input [19:0] a;
        input        df;
        begin
            blk = df ? (a >> `FACS_DBLK_SH) : (a >> `FACS_CBLK_SH);
        end
    endfunction

    // First byte of the block that holds an address
    function [19:0] blk_base;
        input [19:0] a;
        input        df;
        begin
            blk_base = df ? ((a >> `FACS_DBLK_SH) << `FACS_DBLK_SH)
                          : ((a >> `FACS_CBLK_SH) << `FACS_CBLK_SH);
        end
    endfunction

    // ----------------------------------------
    // Flash array
    // ----------------------------------------
    facs_flash_port u_flash
    (
        .sys_clk_i (sys_clk_i),
        .rst_b_i   (rst_b_i),
        .wr_i      (fl_wr),
        .wide_i    (fl_wide),
        .erase_i   (fl_er),
        .addr_i    (cur_q),
        .data_i    (wdata),
        .xwr_i     (fl_xwr),
        .xsel_i    (xsel),
        .byte_o    (fl_byte),
        .xword_o   (fl_xword)
    );

    // Strobes into the array from the state
    always @*
    begin
        fl_wr   = (st_q == S_WR);
        fl_wide = !cur_df;
        fl_er   = (st_q == S_ER);
        fl_xwr  = 1'b0;
        if (st_q == S_XWR)
        begin
            case (xcmd)
                `FACS_XCMD_SHLD: fl_xwr = fl_xword[`FACS_SHLD_LOCK];
                `FACS_XCMD_RDPR: fl_xwr = fl_xword[`FACS_RDPR_LOCK];
                `FACS_XCMD_BOOT: fl_xwr = fl_xword[`FACS_BOOT_LOCK];
                default:         fl_xwr = 1'b0;
            endcase
        end
    end

    // ----------------------------------------
    // Register writes and sequencing
    // ----------------------------------------
    always @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            wdl_q   <= `FACS_ZERO8;
            wdh_q   <= `FACS_ZERO8;
            wdl2_q  <= `FACS_ZERO8;
            wdh2_q  <= `FACS_ZERO8;
            sal_q   <= `FACS_ZERO8;
            sah_q   <= `FACS_ZERO8;
            eal_q   <= `FACS_ZERO8;
            eah_q   <= `FACS_ZERO8;
            xarea_q <= 1'b0;
            msc_q   <= `FACS_ZERO8;
            esc_q   <= `FACS_ZERO8;
            pmc_q   <= 3'h0;
            mdone_q <= 1'b0;
            xdone_q <= 1'b0;
            xerr_q  <= 1'b0;
            berr_q  <= 1'b0;
            st_q    <= S_IDLE;
            cur_q   <= 20'h00000;
            wait_q  <= 1'b0;
        end
        else if (clr_w && stopped)
        begin
            // Mode and status bits survive a register clear
            wdl_q   <= `FACS_ZERO8;
            wdh_q   <= `FACS_ZERO8;
            wdl2_q  <= `FACS_ZERO8;
            wdh2_q  <= `FACS_ZERO8;
            sal_q   <= `FACS_ZERO8;
            sah_q   <= `FACS_ZERO8;
            eal_q   <= `FACS_ZERO8;
            eah_q   <= `FACS_ZERO8;
            xarea_q <= 1'b0;
            msc_q   <= `FACS_ZERO8;
            esc_q   <= `FACS_ZERO8;
        end
        else
        begin
            if (wr_i)
            begin
                if (addr_i == `FACS_A_WDL)
                    wdl_q <= wdata_i;
                else if (addr_i == `FACS_A_WDH)
                    wdh_q <= wdata_i;
                else if (addr_i == `FACS_A_SAL)
                    sal_q <= wdata_i;
                else if (addr_i == `FACS_A_SAH)
                    sah_q <= wdata_i;
                else if (addr_i == `FACS_A_EAL)
                    eal_q <= wdata_i;
                else if (addr_i == `FACS_A_EAH)
                    eah_q <= wdata_i;
                else if (addr_i == `FACS_A_ARS)
                    xarea_q <= wdata_i[`FACS_ARS_XAREA];
                else if (addr_i == `FACS_A_PMC && stopped)
                    pmc_q <= wdata_i[2:0];
                else if (addr_i == `FACS_A_MSC &&
                         ((pmc_q[`FACS_PMC_CPM] && !pmc_q[`FACS_PMC_CPB]) ||
                          pmc_q[`FACS_PMC_DPM]))
                    msc_q <= wdata_i;
                else if (addr_i == `FACS_A_ESC &&
                         pmc_q[`FACS_PMC_CPM] && !pmc_q[`FACS_PMC_CPB])
                    esc_q <= wdata_i;
                else if (addr_i == `FACS_A_STL)
                    wdl2_q <= wdata_i;
                else if (addr_i == `FACS_A_STH)
                    wdh2_q <= wdata_i;
            end
            // Done flags fall when software drops the go bits
            if (!msc_q[`FACS_MSC_GO])
                mdone_q <= 1'b0;
            if (!esc_q[`FACS_ESC_GO])
                xdone_q <= 1'b0;
            case (st_q)
                S_IDLE:
                begin
                    cur_q  <= start_a;
                    wait_q <= 1'b0;
                    if (msc_q[`FACS_MSC_GO] && !mdone_q)
                    begin
                        berr_q <= 1'b0;
                        if (mcmd == `FACS_CMD_WRITE)
                            st_q <= S_WR;
                        else if (mcmd == `FACS_CMD_BCC || mcmd == `FACS_CMD_BCD)
                            st_q <= S_BC;
                        else if (mcmd == `FACS_CMD_ERASE)
                        begin
                            // Erase from the first byte of the start block
                            st_q  <= S_ER;
                            cur_q <= blk_base(start_a, start_df);
                        end
                        else
                            st_q <= S_DONE;
                    end
                    else if (esc_q[`FACS_ESC_GO] && !xdone_q && xarea_q)
                    begin
                        xerr_q <= 1'b0;
                        if (xcmd == `FACS_XCMD_SHLD || xcmd == `FACS_XCMD_RDPR ||
                            xcmd == `FACS_XCMD_BOOT)
                            st_q <= S_XRD;
                        else
                            st_q <= S_DONE;
                    end
                end
                S_WR:
                    st_q <= S_DONE;
                S_BC:
                begin
                    // Read lands one cycle after the address
                    wait_q <= ~wait_q;
                    if (wait_q)
                    begin
                        if (fl_byte != `FACS_ZERO8)
                            berr_q <= 1'b1;
                        if (cur_q >= end_a)
                            st_q <= S_DONE;
                        else
                            cur_q <= cur_q + 20'h00001;
                    end
                end
                S_ER:
                begin
                    // Walk every byte up to the end of the last block
                    if (blk(cur_q, cur_df) > blk(end_a, cur_df) ||
                        cur_q == 20'hFFFFF)
                        st_q <= S_DONE;
                    else
                        cur_q <= cur_q + 20'h00001;
                end
                S_XRD:
                    st_q <= S_XWR;
                S_XWR:
                begin
                    xerr_q <= !fl_xwr;
                    st_q   <= S_DONE;
                end
                S_DONE:
                begin
                    if (esc_q[`FACS_ESC_GO])
                        xdone_q <= 1'b1;
                    else
                        mdone_q <= 1'b1;
                    st_q <= S_IDLE;
                end
                default:
                    st_q <= S_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Read data, one cycle after the strobe
    // ----------------------------------------
    always @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            rdata_o <= 8'h00;
        else if (rd_i)
        begin
            if (addr_i == `FACS_A_WDL)
                rdata_o <= wdl_q;
            else if (addr_i == `FACS_A_WDH)
                rdata_o <= wdh_q;
            else if (addr_i == `FACS_A_SAL)
                rdata_o <= sal_q;
            else if (addr_i == `FACS_A_SAH)
                rdata_o <= sah_q;
            else if (addr_i == `FACS_A_EAL)
                rdata_o <= eal_q;
            else if (addr_i == `FACS_A_EAH)
                rdata_o <= eah_q;
            else if (addr_i == `FACS_A_ARS)
                rdata_o <= {7'h00, xarea_q};
            else if (addr_i == `FACS_A_MSC)
                rdata_o <= msc_q;
            else if (addr_i == `FACS_A_ESC)
                rdata_o <= esc_q;
            else if (addr_i == `FACS_A_PMC)
                rdata_o <= {5'h00, pmc_q};
            else if (addr_i == `FACS_A_STH)
                rdata_o <= {xdone_q, mdone_q, 6'h00};
            else if (addr_i == `FACS_A_STL)
                rdata_o <= {2'h0, xerr_q, 1'b0, berr_q, 3'h0};
            else
                rdata_o <= 8'h00;
        end
    end

    assign main_done_flag_o  = mdone_q;
    assign extra_done_flag_o = xdone_q;
endmodule
`default_nettype wire

// ==== tb/facs_area_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module facs_area_model;
    logic        nz;
    logic [31:0] xw [0:2];
    // Array starts blank, extra words start unlocked
    initial
    begin
        nz = 1'b0;
        xw[0] = 32'hFFFFFFFF;
        xw[1] = 32'hFFFFFFFF;
        xw[2] = 32'hFFFFFFFF;
    end
    // Any set bit written makes the range nonblank
    task wr_main(input logic [31:0] d);
        nz = nz | (d != 32'h00000000);
    endtask
    // One code block spans the whole modelled array
    task erase;
        nz = 1'b0;
    endtask
    // Extra word write, refused when its lock bit is clear
    task xwr(input logic [1:0] i, input logic [31:0] d, output logic e);
        logic lock;
        lock = (i == 2'h0) ? xw[0][15] : (i == 2'h1) ? xw[1][31] : xw[2][9];
        e = ~lock;
        if (lock)
            xw[i] = d;
    endtask
endmodule
`default_nettype wire

// ==== tb/facs_sequencer_props.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "facs_defines.vh"
module facs_sequencer_chk
(
    // Clock and reset
    input wire logic       sys_clk_i,
    input wire logic       rst_b_i,
    // Register port
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [7:0] rdata_o,
    // Status
    input wire logic       main_done_flag_o,
    input wire logic       extra_done_flag_o
);
    logic [2:0] pmc_q;
    logic       ars_q;
    logic       stopped;
    logic       msc_ok;
    logic       esc_ok;
    logic       msc_wr;
    logic       esc_wr;
    logic       main_stop_w;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    // Shadow of the mode and area registers
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            pmc_q <= 3'h0;
            ars_q <= 1'b0;
        end
        else if (wr_i)
        begin
            if (addr_i == `FACS_A_PMC && stopped)
                pmc_q <= wdata_i[2:0];
            if (addr_i == `FACS_A_ARS)
                ars_q <= wdata_i[0];
            if (addr_i == `FACS_A_CLR && wdata_i[0] && stopped)
                ars_q <= 1'b0;
        end
    end
    // Write acceptance terms
    assign stopped = !main_done_flag_o && !extra_done_flag_o;
    assign msc_ok  = (pmc_q[0] && !pmc_q[1]) || pmc_q[2];
    assign esc_ok  = pmc_q[0] && !pmc_q[1];
    assign msc_wr  = wr_i && addr_i == `FACS_A_MSC;
    assign esc_wr  = wr_i && addr_i == `FACS_A_ESC;
    assign main_stop_w = msc_wr && msc_ok && !wdata_i[7];
    sequence s_main_go;
        msc_wr && msc_ok && wdata_i[7] && !main_done_flag_o
            && wdata_i[3:0] == `FACS_CMD_WRITE;
    endsequence
    sequence s_main_stop;
        msc_wr && msc_ok && !wdata_i[7];
    endsequence
    sequence s_extra_go;
        esc_wr && esc_ok && ars_q && wdata_i[7] && !extra_done_flag_o
            && wdata_i[3:0] inside {4'h1, 4'h6, 4'h7};
    endsequence
    property p_main_rise;
        s_main_go |-> ##[1:8] main_done_flag_o;
    endproperty
    property p_main_fall;
        main_done_flag_o ##0 s_main_stop |-> ##2 !main_done_flag_o;
    endproperty
    property p_main_hold;
        main_done_flag_o && !main_stop_w && !$past(main_stop_w) |=> main_done_flag_o;
    endproperty
    property p_msc_refuse;
        msc_wr && !msc_ok && wdata_i[7] && stopped |=> !main_done_flag_o [*4];
    endproperty
    property p_extra_rise;
        s_extra_go |-> ##[1:300] extra_done_flag_o;
    endproperty
    property p_extra_fall;
        extra_done_flag_o && esc_wr && esc_ok && !wdata_i[7] |-> ##2 !extra_done_flag_o;
    endproperty
    property p_esc_refuse;
        esc_wr && !esc_ok && wdata_i[7] && stopped |=> !extra_done_flag_o [*4];
    endproperty
    property p_status;
        rd_i && addr_i == `FACS_A_STH
            |=> rdata_o == {$past(extra_done_flag_o), $past(main_done_flag_o), 6'h00};
    endproperty
    a_main_rise: assert property (p_main_rise) else $error("main done did not rise");
    a_main_fall: assert property (p_main_fall) else $error("main done did not fall");
    a_main_hold: assert property (p_main_hold) else $error("main done dropped");
    a_msc_refuse: assert property (p_msc_refuse) else $error("main ran while locked");
    a_extra_rise: assert property (p_extra_rise) else $error("extra done late");
    a_extra_fall: assert property (p_extra_fall) else $error("extra done stuck");
    a_esc_refuse: assert property (p_esc_refuse) else $error("extra ran while locked");
    a_status: assert property (p_status) else $error("status read wrong");
endmodule
bind facs_sequencer facs_sequencer_chk u_chk (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .main_done_flag_o(main_done_flag_o), .extra_done_flag_o(extra_done_flag_o));
`default_nettype wire

// ==== tb/test_flash_area_command_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "facs_defines.vh"
module test_flash_area_command_sequencer;
    logic       sys_clk_i;
    logic       rst_b_i;
    logic [3:0] addr_i;
    logic [7:0] wdata_i;
    logic       wr_i;
    logic       rd_i;
    wire  [7:0] rdata_o;
    wire        main_done_flag_o;
    wire        extra_done_flag_o;
    integer     n_mismatch;
    integer     n_tests;
    integer     k;
    logic       xerr;
    logic [3:0] xcmd [0:2];
    facs_sequencer dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .main_done_flag_o(main_done_flag_o), .extra_done_flag_o(extra_done_flag_o));
    facs_area_model m ();
    // 20 MHz clock
    initial
        sys_clk_i = 1'b0;
    always #25 sys_clk_i = ~sys_clk_i;
    // ----------------------------------------
    // Bus and check tasks
    // ----------------------------------------
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp)
        begin
            n_mismatch = n_mismatch + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask
    task rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] msk);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1 chk(rdata_o & msk, e & msk);
    endtask
    task wait_flag(input logic x);
        integer n;
        n = 0;
        while (((x ? extra_done_flag_o : main_done_flag_o) !== 1'b1) && n < 3000)
        begin
            @(posedge sys_clk_i);
            #1 n = n + 1;
        end
        // A flag that never rises counts as a mismatch
        if (n >= 3000)
            chk(8'h00, 8'h01);
    endtask
    // Start, see done, then stop
    task go_main(input logic [7:0] ctl, input logic dn);
        wr(`FACS_A_MSC, ctl);
        wait_flag(1'b0);
        if (dn)
            chk({7'h00, main_done_flag_o}, 8'h01);
        wr(`FACS_A_MSC, 8'h00);
        @(posedge sys_clk_i);
        #1 chk({7'h00, main_done_flag_o}, 8'h00);
    endtask
    task go_extra(input logic [3:0] cmd, input logic err);
        wr(`FACS_A_ESC, {4'h8, cmd});
        wait_flag(1'b1);
        chk({7'h00, extra_done_flag_o}, 8'h01);
        rd(`FACS_A_STL, {2'b00, err, 5'h00}, 8'h20);
        wr(`FACS_A_ESC, {4'h0, cmd});
        @(posedge sys_clk_i);
        #1 chk({7'h00, extra_done_flag_o}, 8'h00);
    endtask
    task finish_test;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Watchdog
    initial
    begin
        #1000000;
        n_mismatch = n_mismatch + 1;
        $display("watchdog expired");
        finish_test;
    end
    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial
    begin
        n_mismatch = 0;
        n_tests = 0;
        rst_b_i = 1'b0;
        addr_i = 4'h0;
        wdata_i = 8'h00;
        wr_i = 1'b0;
        rd_i = 1'b0;
        xcmd[0] = `FACS_XCMD_SHLD;
        xcmd[1] = `FACS_XCMD_RDPR;
        xcmd[2] = `FACS_XCMD_BOOT;
        repeat (10) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        rd(`FACS_A_STH, 8'h00, 8'hFF);
        rd(`FACS_A_MSC, 8'h00, 8'hFF);
        rd(`FACS_A_ESC, 8'h00, 8'hFF);
        $display("test reset done");
        wr(`FACS_A_MSC, 8'h81);
        rd(`FACS_A_MSC, 8'h00, 8'hFF);
        wr(`FACS_A_ESC, 8'h81);
        rd(`FACS_A_ESC, 8'h00, 8'hFF);
        wr(`FACS_A_PMC, 8'h04);
        wr(`FACS_A_ESC, 8'h81);
        rd(`FACS_A_ESC, 8'h00, 8'hFF);
        wr(`FACS_A_MSC, 8'h0B);
        rd(`FACS_A_MSC, 8'h0B, 8'hFF);
        wr(`FACS_A_PMC, 8'h03);
        wr(`FACS_A_MSC, 8'h00);
        rd(`FACS_A_MSC, 8'h0B, 8'hFF);
        wr(`FACS_A_PMC, 8'h01);
        wr(`FACS_A_MSC, 8'h00);
        rd(`FACS_A_MSC, 8'h00, 8'hFF);
        $display("test control modes done");
        // Aligned start and end addresses, nonzero data
        wr(`FACS_A_SAL, 8'h00);
        wr(`FACS_A_SAH, 8'h00);
        wr(`FACS_A_STH, 8'h10);
        wr(`FACS_A_EAL, 8'h00);
        wr(`FACS_A_EAH, 8'h00);
        wr(`FACS_A_STL, 8'h10);
        wr(`FACS_A_WDL, 8'h5A);
        wr(`FACS_A_WDH, 8'hA5);
        go_main(8'h81, 1'b1);
        m.wr_main({8'hA5, 8'h10, 8'h5A, 8'h10});
        go_main(8'h83, 1'b1);
        rd(`FACS_A_STL, {4'h0, m.nz, 3'h0}, 8'h08);
        wr(`FACS_A_STH, 8'h14);
        go_main(8'h84, 1'b1);
        m.erase;
        wr(`FACS_A_STH, 8'h10);
        go_main(8'h82, 1'b0);
        go_main(8'h83, 1'b1);
        rd(`FACS_A_STL, {4'h0, m.nz, 3'h0}, 8'h08);
        wr(`FACS_A_SAH, 8'h0F);
        wr(`FACS_A_SAL, 8'h10);
        go_main(8'h8B, 1'b1);
        rd(`FACS_A_STL, {4'h0, m.nz, 3'h0}, 8'h08);
        $display("test main commands done");
        // Clear is ignored while a done flag stands
        wr(`FACS_A_SAL, 8'h33);
        wr(`FACS_A_MSC, 8'h83);
        wait_flag(1'b0);
        wr(`FACS_A_CLR, 8'h01);
        rd(`FACS_A_SAL, 8'h33, 8'hFF);
        wr(`FACS_A_MSC, 8'h00);
        wr(`FACS_A_CLR, 8'h01);
        rd(`FACS_A_SAL, 8'h00, 8'hFF);
        rd(`FACS_A_MSC, 8'h00, 8'hFF);
        rd(`FACS_A_ARS, 8'h00, 8'hFF);
        $display("test register clear done");
        // Each extra word: first write locks it, second is refused
        wr(`FACS_A_ARS, 8'h01);
        wr(`FACS_A_WDL, 8'h00);
        wr(`FACS_A_WDH, 8'h00);
        for (k = 0; k < 6; k = k + 1)
        begin
            m.xwr(k[2:1], 32'h00000000, xerr);
            go_extra(xcmd[k[2:1]], xerr);
        end
        $display("test extra commands done");
        finish_test;
    end
endmodule
`default_nettype wire
